// [psc_pkg.sv]
// package: register map, field layout and reset values of the power supply control bank
package psc_pkg;
  localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'h2C;
  localparam logic [7:0] ADDR_SUPPLY_STATUS = 8'h30;
  localparam logic [7:0] ADDR_CORE_RAIL_LEVEL = 8'h34;
  localparam logic [7:0] ADDR_PLL_REGULATOR_LEVEL = 8'h40;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h50;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h54;
  // converter_control field positions
  localparam int PG_LEVEL_LSB = 24;
  localparam int ERR_CLEAR_BIT = 16;
  localparam int ANA_ILIM_LSB = 13;
  localparam int ANA_CLK_LSB = 8;
  localparam int CORE_ILIM_LSB = 5;
  localparam int CORE_CLK_LSB = 0;
  localparam logic [1:0] PG_LEVEL_RESET = 2'h2;
  localparam logic [1:0] ANA_ILIM_RESET = 2'h0;
  localparam logic [1:0] ANA_CLK_RESET = 2'h1;
  localparam logic [1:0] CORE_ILIM_RESET = 2'h0;
  localparam logic [1:0] CORE_CLK_RESET = 2'h1;
  // supply_status bit positions
  localparam int ST_OSC_STABLE = 24;
  localparam int ST_PLL_GOOD = 19;
  localparam int ST_CORE_GOOD = 16;
  localparam int ST_ANA_ILIM = 9;
  localparam int ST_CORE_ILIM = 8;
  localparam int ST_ANA_SOFT = 1;
  localparam int ST_CORE_SOFT = 0;
  localparam int CORE_LEVEL_W = 7;
  localparam int PLL_LEVEL_W = 3;
  localparam logic [6:0] CORE_LEVEL_MAX = 7'h46;
  localparam int NUM_EVENTS = 7;
endpackage

// [psc_sync.sv]
// two-flop synchroniser bank for asynchronous status levels
`timescale 1ns/10ps
module psc_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync_out;

  always_comb
  begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule

// [psc_regs.sv]
// register bank for the converter and regulator controls and supply status
//
// Summary of operation
// - two-bit power-good level for core rail and 1.8 V rail, resets to 2.
// - clear bit clears both converter error flags; stays until software writes zero.
// - two-bit analogue converter current limit field, resets to 0.
// - two-bit analogue converter switching clock field, resets to 1.
// - two-bit core converter current limit field, resets to 0.
// - two-bit core converter switching clock field, resets to 1.
// - status shows oscillator stable, pll rail good, core rail good.
// - status shows current limiting of analogue and core converters.
// - status shows soft-start of analogue and core converters.
// - seven-bit core rail target, 0.60 V plus 10 mV per code, 0 to 70.
// - both voltage fields load their start value from the strap pins on the first clock after reset release.
// - three-bit pll regulator target, 0.6 V plus 100 mV per code.
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
module psc_regs (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [6:0] strap_core_level,
  input wire logic [2:0] strap_pll_level,
  input wire logic osc_stable,
  input wire logic pll_rail_good,
  input wire logic core_rail_good,
  input wire logic analog_buck_converter_ilim,
  input wire logic core_buck_converter_ilim,
  input wire logic analog_buck_converter_soft,
  input wire logic core_buck_converter_soft,
  output logic [1:0] pg_level,
  output logic err_clear,
  output logic [1:0] analog_buck_converter_ilim_sel,
  output logic [1:0] analog_buck_converter_clk_sel,
  output logic [1:0] core_buck_converter_ilim_sel,
  output logic [1:0] core_buck_converter_clk_sel,
  output logic [6:0] core_rail_level,
  output logic [2:0] pll_linear_regulator_level,
  output logic irq
);
  localparam int NE = psc_pkg::NUM_EVENTS;

  logic [NE-1:0] st_raw;
  logic [NE-1:0] st_sync;
  logic [NE-1:0] st_prev;
  logic strap_done;
  logic [NE-1:0] irq_status;
  logic [NE-1:0] irq_mask;
  logic [1:0] next_pg_level;
  logic next_err_clear;
  logic [1:0] next_ana_ilim;
  logic [1:0] next_ana_clk;
  logic [1:0] next_core_ilim;
  logic [1:0] next_core_clk;
  logic [6:0] next_core_level;
  logic [2:0] next_pll_level;
  logic next_strap_done;
  logic [NE-1:0] next_irq_status;
  logic [NE-1:0] next_irq_mask;
  logic [NE-1:0] next_st_prev;
  logic [31:0] next_rdata;
  logic next_irq;

  assign st_raw = {osc_stable, pll_rail_good, core_rail_good, analog_buck_converter_ilim,
                   core_buck_converter_ilim, analog_buck_converter_soft,
                   core_buck_converter_soft};

  psc_sync #(.W(NE)) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(st_raw),
    .sync_out(st_sync)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
    hit = (a == ref_addr);
  endfunction

  // status word from synchronised levels, reserved bits zero
  function automatic logic [31:0] status_word(input logic [NE-1:0] s);
    logic [31:0] w;
    w = 32'h0;
    w[psc_pkg::ST_OSC_STABLE] = s[6];
    w[psc_pkg::ST_PLL_GOOD] = s[5];
    w[psc_pkg::ST_CORE_GOOD] = s[4];
    w[psc_pkg::ST_ANA_ILIM] = s[3];
    w[psc_pkg::ST_CORE_ILIM] = s[2];
    w[psc_pkg::ST_ANA_SOFT] = s[1];
    w[psc_pkg::ST_CORE_SOFT] = s[0];
    status_word = w;
  endfunction

  always_comb
  begin
    next_pg_level = pg_level;
    next_err_clear = err_clear;
    next_ana_ilim = analog_buck_converter_ilim_sel;
    next_ana_clk = analog_buck_converter_clk_sel;
    next_core_ilim = core_buck_converter_ilim_sel;
    next_core_clk = core_buck_converter_clk_sel;
    next_core_level = core_rail_level;
    next_pll_level = pll_linear_regulator_level;
    next_irq_mask = irq_mask;
    next_strap_done = 1'b1;
    next_st_prev = st_sync;
    // strap capture
    // straps are caught on the first clock after release, since async reset loads constants only
    if (!strap_done)
    begin
      next_core_level = strap_core_level;
      next_pll_level = strap_pll_level;
    end
    else if (wr)
    begin
      if (hit(addr, psc_pkg::ADDR_CONVERTER_CONTROL))
      begin
        next_pg_level = wdata[psc_pkg::PG_LEVEL_LSB +: 2];
        next_err_clear = wdata[psc_pkg::ERR_CLEAR_BIT];
        next_ana_ilim = wdata[psc_pkg::ANA_ILIM_LSB +: 2];
        next_ana_clk = wdata[psc_pkg::ANA_CLK_LSB +: 2];
        next_core_ilim = wdata[psc_pkg::CORE_ILIM_LSB +: 2];
        next_core_clk = wdata[psc_pkg::CORE_CLK_LSB +: 2];
      end
      // core rail target
      // codes above 70 are stored as written; the converter is left to clamp
      if (hit(addr, psc_pkg::ADDR_CORE_RAIL_LEVEL))
        next_core_level = wdata[psc_pkg::CORE_LEVEL_W-1:0];
      if (hit(addr, psc_pkg::ADDR_PLL_REGULATOR_LEVEL))
        next_pll_level = wdata[psc_pkg::PLL_LEVEL_W-1:0];
      if (hit(addr, psc_pkg::ADDR_IRQ_MASK))
        next_irq_mask = wdata[NE-1:0];
    end
    // events are status changes; set wins over write-one-to-clear
    next_irq_status = irq_status;
    if (wr && strap_done && hit(addr, psc_pkg::ADDR_IRQ_STATUS))
      next_irq_status = irq_status & ~wdata[NE-1:0];
    next_irq_status = next_irq_status | (st_sync ^ st_prev);
    next_irq = |(next_irq_status & next_irq_mask);
    next_rdata = 32'h0;
    if (rd)
    begin
      case (addr)
        psc_pkg::ADDR_CONVERTER_CONTROL:
        begin
          next_rdata[psc_pkg::PG_LEVEL_LSB +: 2] = pg_level;
          next_rdata[psc_pkg::ERR_CLEAR_BIT] = err_clear;
          next_rdata[psc_pkg::ANA_ILIM_LSB +: 2] = analog_buck_converter_ilim_sel;
          next_rdata[psc_pkg::ANA_CLK_LSB +: 2] = analog_buck_converter_clk_sel;
          next_rdata[psc_pkg::CORE_ILIM_LSB +: 2] = core_buck_converter_ilim_sel;
          next_rdata[psc_pkg::CORE_CLK_LSB +: 2] = core_buck_converter_clk_sel;
        end
        psc_pkg::ADDR_SUPPLY_STATUS: next_rdata = status_word(st_sync);
        psc_pkg::ADDR_CORE_RAIL_LEVEL: next_rdata[6:0] = core_rail_level;
        psc_pkg::ADDR_PLL_REGULATOR_LEVEL: next_rdata[2:0] = pll_linear_regulator_level;
        psc_pkg::ADDR_IRQ_STATUS: next_rdata[NE-1:0] = irq_status;
        psc_pkg::ADDR_IRQ_MASK: next_rdata[NE-1:0] = irq_mask;
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pg_level <= psc_pkg::PG_LEVEL_RESET;
      err_clear <= 1'b0;
      analog_buck_converter_ilim_sel <= psc_pkg::ANA_ILIM_RESET;
      analog_buck_converter_clk_sel <= psc_pkg::ANA_CLK_RESET;
      core_buck_converter_ilim_sel <= psc_pkg::CORE_ILIM_RESET;
      core_buck_converter_clk_sel <= psc_pkg::CORE_CLK_RESET;
      core_rail_level <= 7'h00;
      pll_linear_regulator_level <= 3'h0;
      strap_done <= 1'b0;
      irq_status <= '0;
      irq_mask <= '0;
      st_prev <= '0;
      rdata <= 32'h0;
      irq <= 1'b0;
    end
    else
    begin
      pg_level <= next_pg_level;
      err_clear <= next_err_clear;
      analog_buck_converter_ilim_sel <= next_ana_ilim;
      analog_buck_converter_clk_sel <= next_ana_clk;
      core_buck_converter_ilim_sel <= next_core_ilim;
      core_buck_converter_clk_sel <= next_core_clk;
      core_rail_level <= next_core_level;
      pll_linear_regulator_level <= next_pll_level;
      strap_done <= next_strap_done;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      st_prev <= next_st_prev;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  a_pg_level_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    strap_done && wr && addr == psc_pkg::ADDR_CONVERTER_CONTROL |=> pg_level == $past(wdata[25:24]))
    else $error("pg level not written");
  a_err_clear_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    err_clear && !(wr && addr == psc_pkg::ADDR_CONVERTER_CONTROL) |=> err_clear)
    else $error("clear bit dropped by hardware");
  a_ana_ilim_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    strap_done && wr && addr == psc_pkg::ADDR_CONVERTER_CONTROL
    |=> analog_buck_converter_ilim_sel == $past(wdata[14:13]))
    else $error("analogue current limit not written");
  a_ana_clk_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    strap_done && wr && addr == psc_pkg::ADDR_CONVERTER_CONTROL
    |=> analog_buck_converter_clk_sel == $past(wdata[9:8]))
    else $error("analogue clock not written");
  a_core_ilim_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    strap_done && wr && addr == psc_pkg::ADDR_CONVERTER_CONTROL
    |=> core_buck_converter_ilim_sel == $past(wdata[6:5]))
    else $error("core current limit not written");
  a_core_clk_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    strap_done && wr && addr == psc_pkg::ADDR_CONVERTER_CONTROL
    |=> core_buck_converter_clk_sel == $past(wdata[1:0]))
    else $error("core clock not written");
  a_status_read: assert property (@(posedge sys_clk) disable iff (!rstn)
    rd && addr == psc_pkg::ADDR_SUPPLY_STATUS
    |=> rdata[24] == $past(st_sync[6]) && rdata[19] == $past(st_sync[5]) && rdata[0] == $past(st_sync[0]))
    else $error("status read mismatch");
  a_core_level_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    strap_done && wr && addr == psc_pkg::ADDR_CORE_RAIL_LEVEL |=> core_rail_level == $past(wdata[6:0]))
    else $error("core rail level not written");
  a_strap_load: assert property (@(posedge sys_clk) disable iff (!rstn)
    !strap_done |=> core_rail_level == $past(strap_core_level) && strap_done)
    else $error("strap not captured");
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    rd && addr == psc_pkg::ADDR_PLL_REGULATOR_LEVEL |=> rdata[31:3] == 29'h0)
    else $error("reserved bits not zero");
  c_irq_raised: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(irq));
  c_err_clear_set: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(err_clear));
  c_status_read: cover property (@(posedge sys_clk) disable iff (!rstn)
    rd && addr == psc_pkg::ADDR_SUPPLY_STATUS);
endmodule

// [psc_conv_model.sv]
// behavioural converters and supply monitors that drive the status levels
`timescale 1ns/10ps
module psc_conv_model (
  input wire logic sys_clk,
  input wire logic [6:0] set_stat,
  output logic [6:0] stat
);
  initial stat = 7'h00;
  // levels move off the edge: the bank must treat them as asynchronous
  always @(posedge sys_clk)
  begin
    #1;
    stat <= set_stat;
  end
endmodule

// [testbench.sv]
// self-checking bench for the power supply control register bank
`timescale 1ns/10ps
module testbench;
  logic sys_clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, err_clear, irq;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [6:0] strap_core = 7'h00, set_stat = 7'h00, stat, core_lvl;
  logic [2:0] strap_pll = 3'h0, pll_lvl;
  logic [1:0] pg_level, ana_ilim, ana_clk, core_ilim, core_clk;
  int bad_count = 0, total_checks = 0, seed = 32'h8ba7;
  int exp_ctrl, exp_ist, exp_msk, c;
  always #2 sys_clk = ~sys_clk;
  psc_conv_model psc_conv_model_inst (.sys_clk(sys_clk), .set_stat(set_stat), .stat(stat));
  psc_regs psc_regs_inst (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .strap_core_level(strap_core),
    .strap_pll_level(strap_pll), .osc_stable(stat[6]), .pll_rail_good(stat[5]),
    .core_rail_good(stat[4]), .analog_buck_converter_ilim(stat[3]),
    .core_buck_converter_ilim(stat[2]), .analog_buck_converter_soft(stat[1]),
    .core_buck_converter_soft(stat[0]), .pg_level(pg_level), .err_clear(err_clear),
    .analog_buck_converter_ilim_sel(ana_ilim), .analog_buck_converter_clk_sel(ana_clk),
    .core_buck_converter_ilim_sel(core_ilim), .core_buck_converter_clk_sel(core_clk),
    .core_rail_level(core_lvl), .pll_linear_regulator_level(pll_lvl), .irq(irq));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  function automatic logic [31:0] ctrl_out();
    return {6'h0, pg_level, 7'h0, err_clear, 1'b0, ana_ilim, 3'h0, ana_clk, 1'b0,
      core_ilim, 3'h0, core_clk};
  endfunction
  function automatic logic [31:0] stat_word(input int s);
    return 32'((s >> 6 & 1) << 24 | (s >> 5 & 1) << 19 | (s >> 4 & 1) << 16
      | (s >> 3 & 1) << 9 | (s >> 2 & 1) << 8 | (s & 3));
  endfunction
  // each status edge is an event once synchronised
  // old events are cleared first so that each step can show irq low as well as high
  task automatic set_status(input int s);
    wr_reg(psc_pkg::ADDR_IRQ_STATUS, 32'h7F);
    exp_ist = 0;
    set_stat <= 7'(s);
    exp_ist = (s ^ int'(set_stat)) & 32'h7F;
    repeat (6) @(posedge sys_clk);
    #1;
    chk(32'(irq), 32'((exp_ist & exp_msk) != 0));
    rd_chk(psc_pkg::ADDR_SUPPLY_STATUS, stat_word(s));
    rd_chk(psc_pkg::ADDR_IRQ_STATUS, 32'(exp_ist));
  endtask
  initial
  begin
    strap_core = 7'($unsigned($random(seed)) % 71);
    strap_pll = 3'($random(seed));
    exp_ist = 0;
    exp_msk = 0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(32'(core_lvl), 32'(strap_core));
    chk(32'(pll_lvl), 32'(strap_pll));
    chk(ctrl_out(), 32'h0200_0101);
    rd_chk(psc_pkg::ADDR_CONVERTER_CONTROL, 32'h0200_0101);
    rd_chk(psc_pkg::ADDR_CORE_RAIL_LEVEL, 32'(strap_core));
    $display("reset values done");
    for (c = 0; c < 4; c++)
    begin
      exp_ctrl = c << 24 | (c & 1) << 16 | c << 13 | c << 8 | c << 5 | c;
      wr_reg(psc_pkg::ADDR_CONVERTER_CONTROL, ($random(seed) & ~32'h0301_6363) | exp_ctrl);
      chk(ctrl_out(), exp_ctrl);
      rd_chk(psc_pkg::ADDR_CONVERTER_CONTROL, exp_ctrl);
    end
    $display("converter control done");
    // one code per 250 cycles keeps the ramp within 10 mV per microsecond
    for (c = strap_core; c <= 70; c++)
    begin
      wr_reg(psc_pkg::ADDR_CORE_RAIL_LEVEL, ($random(seed) & ~32'h7F) | c);
      chk(32'(core_lvl), c);
      repeat (250) @(posedge sys_clk);
    end
    rd_chk(psc_pkg::ADDR_CORE_RAIL_LEVEL, 32'd70);
    chk(32'(err_clear), 32'h1);
    // software must take the clear bit back down itself
    wr_reg(psc_pkg::ADDR_CONVERTER_CONTROL, 32'h0200_0101);
    chk(ctrl_out(), 32'h0200_0101);
    for (c = strap_pll; c <= 7; c++)
    begin
      wr_reg(psc_pkg::ADDR_PLL_REGULATOR_LEVEL, ($random(seed) & ~32'h7) | c);
      chk(32'(pll_lvl), c);
      rd_chk(psc_pkg::ADDR_PLL_REGULATOR_LEVEL, c);
    end
    $display("voltage levels done");
    set_status(7'h0C);
    rd_chk(psc_pkg::ADDR_IRQ_STATUS, 32'h0C);
    wr_reg(psc_pkg::ADDR_IRQ_MASK, 32'hFFFF_FF7F);
    exp_msk = 32'h7F;
    rd_chk(psc_pkg::ADDR_IRQ_MASK, 32'h7F);
    for (c = 0; c < 7; c++)
      set_status(1 << c);
    set_status(7'h7F);
    // no change of level: no event, irq must stay low
    set_status(7'h7F);
    wr_reg(psc_pkg::ADDR_SUPPLY_STATUS, 32'h0);
    rd_chk(psc_pkg::ADDR_SUPPLY_STATUS, stat_word(7'h7F));
    wr_reg(8'h3C, 32'hFFFF_FFFF);
    rd_chk(8'h3C, 32'h0);
    wr_reg(psc_pkg::ADDR_IRQ_STATUS, 32'h7F);
    exp_ist = 0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(32'(irq), 32'h0);
    rd_chk(psc_pkg::ADDR_IRQ_STATUS, 32'h0);
    $display("status and interrupt done");
    // second reset in mid-run with new strap levels
    @(posedge sys_clk);
    rstn <= 1'b0;
    strap_core <= 7'($unsigned($random(seed)) % 71);
    strap_pll <= 3'($random(seed));
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(32'(core_lvl), 32'(strap_core));
    chk(32'(pll_lvl), 32'(strap_pll));
    chk(ctrl_out(), 32'h0200_0101);
    chk(32'(irq), 32'h0);
    rd_chk(psc_pkg::ADDR_IRQ_MASK, 32'h0);
    $display("mid-run reset done");
    print_verdict();
  end
endmodule
